// file: pmr_result_bank.sv
// result register bank of a single-channel power monitor
//
// Overview of operation
// - accumulate power by default, else bus or sense
// - accumulator 56 bits, signed when its source is bipolar (power: either input)
// - refresh clears accumulator, retain keeps it
// - changed source after retain mixes old sums
// - voltage addends 16 bits, power addends 32
// - power signed inside, unsigned when both unipolar
// - accumulator never adds negative contributions in unipolar
// - bus sample latest, never cleared by refresh
// - sense sample latest, never cleared by refresh
// - bus rolling mean, never cleared by refresh
// - sense rolling mean, never cleared by refresh
// - single read of unfilled mean gets nack
// - bulk read returns unfilled mean without nack
// - power product 32 bits feeds the accumulator
// - power product never cleared by refresh
// - bus minimum from single conversions
// - bus maximum from single conversions
// - sense minimum from single conversions
// - refresh clears min/max, retain keeps them
// - power uses wider operands than reported voltages
// - any refresh moves accumulator to readable copy
module pmr_result_bank
    import pmr_pkg::*;
#(
    parameter int RAW_W     = 20,
    parameter int AVG_DEPTH = 8
) (
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              rst,
    // conversion results from the converter
    input  wire logic              conv_valid,
    input  wire logic [RAW_W-1:0]  conv_bus,
    input  wire logic [RAW_W-1:0]  conv_sense,
    // active configuration
    input  wire logic              bus_bipolar,
    input  wire logic              sense_bipolar,
    input  wire logic [1:0]        accumulate_source_select,
    // refresh commands
    input  wire logic              refresh,
    input  wire logic              refresh_retain,
    // register read port
    input  wire logic              rd_req,
    input  wire logic [7:0]        rd_addr,
    input  wire logic              rd_bulk,
    output logic                   rd_ack,
    output logic                   rd_nack,
    output logic [PMR_ACC_W-1:0]   rd_data
);

    // derived widths; a depth that is not a power of two skews the mean
    localparam int LOG_D  = $clog2(AVG_DEPTH);
    localparam int SUM_W  = PMR_VOLT_W + LOG_D + 1;
    localparam int PROD_W = 2 * RAW_W + 2;
    localparam int PTOP   = 2 * RAW_W - 1;

    // widen a 16-bit result for the running sums
    // unipolar codes are zero-extended, bipolar ones sign-extended
    function automatic logic [SUM_W-1:0] widen(input logic [15:0] v,
                                               input logic bip);
        widen = bip ? {{(SUM_W-16){v[15]}}, v} : {{(SUM_W-16){1'b0}}, v};
    endfunction

    // compare two results in the active format
    // bipolar results compare signed, unipolar ones unsigned
    function automatic logic below(input logic [15:0] a,
                                   input logic [15:0] b,
                                   input logic bip);
        below = bip ? ($signed(a) < $signed(b)) : (a < b);
    endfunction

    // conversion pipeline
    // one conversion takes two edges from strobe to result
    logic [RAW_W-1:0]        bus_raw_q;     // captured bus operand
    logic [RAW_W-1:0]        sense_raw_q;   // captured sense operand
    logic                    stage_q;       // second pipeline step
    logic [LOG_D-1:0]        ptr_q;         // history write slot
    logic [LOG_D:0]          fill_q;        // samples in history
    logic                    avg_full;      // history holds a valid mean
    logic [31:0]             old_pair;      // oldest bus/sense pair
    logic                    mean_refused;  // single read of unfilled mean

    // result registers
    logic [15:0]             bus_sample_q;
    logic [15:0]             sense_sample_q;
    logic [SUM_W-1:0]        bus_sum_q;
    logic [SUM_W-1:0]        sense_sum_q;
    logic [SUM_W-1:0]        bus_sum_d;
    logic [SUM_W-1:0]        sense_sum_d;
    logic [15:0]             bus_mean_q;
    logic [15:0]             sense_mean_q;
    logic [31:0]             power_q;
    logic [15:0]             bus_min_q;
    logic [15:0]             bus_max_q;
    logic [15:0]             sense_min_q;
    logic                    mm_empty_q;    // min/max awaiting first load
    logic [PMR_ACC_W-1:0]    acc_q;         // running accumulator
    logic [PMR_ACC_W-1:0]    acc_rd_q;      // readable copy

    // arithmetic of the second step
    // wide operands keep the power finer than the reported voltages
    logic [15:0]             bus16;
    logic [15:0]             sense16;
    logic signed [RAW_W:0]   bus_op;
    logic signed [RAW_W:0]   sense_op;
    logic signed [PROD_W-1:0] prod;
    logic [31:0]             prod32;
    logic                    any_bip;
    logic [PMR_ACC_W-1:0]    addend;

    // the mean only counts as valid once every slot holds a sample;
    // refresh leaves the window alone, so a valid mean stays valid
    assign avg_full = (fill_q == (LOG_D+1)'(AVG_DEPTH));

    // a single read of a mean is refused until the window is full
    assign mean_refused = !rd_bulk && !avg_full;

    // sample history, shared by both channels; one word holds a pair,
    // so a single read fetches both samples that leave the window
    pmr_avg_buffer #(
        .WIDTH (32),
        .DEPTH (AVG_DEPTH)
    ) u_hist (
        .ref_clk (ref_clk),
        .wr_en   (stage_q),
        .wr_addr (ptr_q),
        .wr_data ({bus16, sense16}),
        .rd_en   (conv_valid),
        .rd_addr (ptr_q),
        .rd_data (old_pair)
    );

    // first step: capture operands while the oldest pair is fetched
    // operands hold between conversions, so the results stay still
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            bus_raw_q   <= '0;
            sense_raw_q <= '0;
            stage_q     <= 1'b0;
        end else begin
            stage_q <= conv_valid;
            if (conv_valid) begin
                bus_raw_q   <= conv_bus;
                sense_raw_q <= conv_sense;
            end
        end
    end

    // history pointer and fill level; never touched by refresh
    // the fill level stops at the depth and never wraps
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ptr_q  <= '0;
            fill_q <= '0;
        end else if (stage_q) begin
            ptr_q <= ptr_q + 1'b1;
            if (!avg_full) begin
                fill_q <= fill_q + 1'b1;
            end
        end
    end

    // reported voltages keep only the top bits of the wide operands
    assign bus16   = bus_raw_q[RAW_W-1 -: 16];
    assign sense16 = sense_raw_q[RAW_W-1 -: 16];
    assign any_bip = bus_bipolar | sense_bipolar;

    // power is always a signed product of the full-width operands
    // a unipolar operand gets a zero sign bit and can never go negative
    always_comb begin
        bus_op   = $signed({bus_bipolar & bus_raw_q[RAW_W-1], bus_raw_q});
        sense_op = $signed({sense_bipolar & sense_raw_q[RAW_W-1],
                            sense_raw_q});
        prod     = PROD_W'(bus_op * sense_op);
        prod32   = prod[PTOP -: 32];
    end

    // addend selection; reserved code falls back to power
    // voltage addends are 16 bits wide, power addends 32
    always_comb begin
        case (pmr_src_type'(accumulate_source_select))
            PMR_SRC_BUS: begin
                addend = bus_bipolar ? {{40{bus16[15]}}, bus16}
                                     : {40'h00_0000_0000, bus16};
            end
            PMR_SRC_SENSE: begin
                addend = sense_bipolar ? {{40{sense16[15]}}, sense16}
                                       : {40'h00_0000_0000, sense16};
            end
            default: begin
                // a negative product is still summed signed
                addend = {{24{any_bip ? prod32[31] : prod[PROD_W-1]}},
                          prod32};
            end
        endcase
    end

    // latest samples and power, untouched by refresh
    // with both inputs unipolar the product cannot be negative; the zero
    // guard only matters if the operand widths are ever changed
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            bus_sample_q   <= PMR_VOLT_RST;
            sense_sample_q <= PMR_VOLT_RST;
            power_q        <= PMR_POWER_RST;
        end else if (stage_q) begin
            bus_sample_q   <= bus16;
            sense_sample_q <= sense16;
            // unipolar power never shows a negative code
            if (!any_bip && prod[PROD_W-1]) begin
                power_q <= PMR_POWER_RST;
            end else begin
                power_q <= prod32;
            end
        end
    end

    // running sums: add newest, drop oldest once history is full
    // while filling nothing leaves the window, so the mean ramps up
    always_comb begin
        bus_sum_d   = bus_sum_q + widen(bus16, bus_bipolar);
        sense_sum_d = sense_sum_q + widen(sense16, sense_bipolar);
        if (avg_full) begin
            bus_sum_d   = bus_sum_d - widen(old_pair[31:16], bus_bipolar);
            sense_sum_d = sense_sum_d - widen(old_pair[15:0], sense_bipolar);
        end
    end

    // rolling means; refresh has no effect here
    // the division by the depth is a plain slice of the sum
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            bus_sum_q    <= '0;
            sense_sum_q  <= '0;
            bus_mean_q   <= PMR_VOLT_RST;
            sense_mean_q <= PMR_VOLT_RST;
        end else if (stage_q) begin
            bus_sum_q    <= bus_sum_d;
            sense_sum_q  <= sense_sum_d;
            bus_mean_q   <= bus_sum_d[LOG_D +: 16];
            sense_mean_q <= sense_sum_d[LOG_D +: 16];
        end
    end

    // min/max tracking; a conversion in the refresh cycle still loads
    // the empty flag makes the first result load instead of compare
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            bus_min_q   <= PMR_VOLT_RST;
            bus_max_q   <= PMR_VOLT_RST;
            sense_min_q <= PMR_VOLT_RST;
            mm_empty_q  <= 1'b1;
        end else if (stage_q && (mm_empty_q || refresh)) begin
            bus_min_q   <= bus16;
            bus_max_q   <= bus16;
            sense_min_q <= sense16;
            mm_empty_q  <= 1'b0;
        end else if (refresh) begin
            // zero until the next conversion reloads them
            bus_min_q   <= PMR_VOLT_RST;
            bus_max_q   <= PMR_VOLT_RST;
            sense_min_q <= PMR_VOLT_RST;
            mm_empty_q  <= 1'b1;
        end else if (stage_q) begin
            if (below(bus16, bus_min_q, bus_bipolar)) begin
                bus_min_q <= bus16;
            end
            if (below(bus_max_q, bus16, bus_bipolar)) begin
                bus_max_q <= bus16;
            end
            if (below(sense16, sense_min_q, sense_bipolar)) begin
                sense_min_q <= sense16;
            end
        end
    end

    // accumulator; the readable copy changes only on a refresh
    // no overflow flag here: the alert logic lives outside this bank
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            acc_q    <= PMR_ACC_RST;
            acc_rd_q <= PMR_ACC_RST;
        end else begin
            if (refresh || refresh_retain) begin
                acc_rd_q <= acc_q;
            end
            if (refresh) begin
                // a sample in the refresh cycle opens the new period
                acc_q <= stage_q ? addend : PMR_ACC_RST;
            end else if (stage_q) begin
                // wraps modulo 2^56, two's complement when signed
                acc_q <= acc_q + addend;
            end
        end
    end

    // read port: answer one cycle after the request
    // data clear on every request, so a refused read shows zero
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rd_ack  <= 1'b0;
            rd_nack <= 1'b0;
            rd_data <= PMR_ACC_RST;
        end else begin
            rd_ack  <= 1'b0;
            rd_nack <= 1'b0;
            if (rd_req) begin
                rd_ack  <= 1'b1;
                rd_data <= PMR_ACC_RST;
                case (rd_addr)
                    // only the accumulator fills the whole word
                    PMR_OFS_ENERGY_ACC:   rd_data <= acc_rd_q;
                    PMR_OFS_BUS_SAMPLE:   rd_data[15:0] <= bus_sample_q;
                    PMR_OFS_SENSE_SAMPLE: rd_data[15:0] <= sense_sample_q;
                    PMR_OFS_BUS_MEAN, PMR_OFS_SENSE_MEAN: begin
                        if (mean_refused) begin
                            // refused read leaves the cleared data
                            rd_ack  <= 1'b0;
                            rd_nack <= 1'b1;
                        end else begin
                            // a bulk read shows even an unfilled mean
                            rd_data[15:0] <= (rd_addr == PMR_OFS_BUS_MEAN)
                                             ? bus_mean_q
                                             : sense_mean_q;
                        end
                    end
                    PMR_OFS_POWER:        rd_data[31:0] <= power_q;
                    PMR_OFS_BUS_MIN:      rd_data[15:0] <= bus_min_q;
                    PMR_OFS_BUS_MAX:      rd_data[15:0] <= bus_max_q;
                    PMR_OFS_SENSE_MIN:    rd_data[15:0] <= sense_min_q;
                    default: begin
                        // unmapped offset is refused
                        rd_ack  <= 1'b0;
                        rd_nack <= 1'b1;
                    end
                endcase
            end
        end
    end

endmodule

// file: pmr_pkg.sv
// shared constants of the power monitor result bank
package pmr_pkg;

    // register offsets on the result read port
    localparam logic [7:0] PMR_OFS_ENERGY_ACC  = 8'h03;
    localparam logic [7:0] PMR_OFS_BUS_SAMPLE  = 8'h04;
    localparam logic [7:0] PMR_OFS_SENSE_SAMPLE = 8'h05;
    localparam logic [7:0] PMR_OFS_BUS_MEAN    = 8'h06;
    localparam logic [7:0] PMR_OFS_SENSE_MEAN  = 8'h07;
    localparam logic [7:0] PMR_OFS_POWER       = 8'h08;
    localparam logic [7:0] PMR_OFS_BUS_MIN     = 8'h09;
    localparam logic [7:0] PMR_OFS_BUS_MAX     = 8'h0A;
    localparam logic [7:0] PMR_OFS_SENSE_MIN   = 8'h0B;

    // result widths
    localparam int PMR_VOLT_W  = 16;
    localparam int PMR_POWER_W = 32;
    localparam int PMR_ACC_W   = 56;

    // reset values
    localparam logic [15:0] PMR_VOLT_RST  = 16'h0000;
    localparam logic [31:0] PMR_POWER_RST = 32'h0000_0000;
    localparam logic [55:0] PMR_ACC_RST   = 56'h00_0000_0000_0000;

    // accumulated quantity selection
    typedef enum logic [1:0] {
        PMR_SRC_POWER = 2'h0,
        PMR_SRC_BUS   = 2'h1,
        PMR_SRC_SENSE = 2'h2,
        PMR_SRC_RSVD  = 2'h3
    } pmr_src_type;

endpackage

// file: pmr_avg_buffer.sv
// sample history memory for the rolling averages, registered read
module pmr_avg_buffer #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    // clock
    input  wire logic                     ref_clk,
    // write port
    input  wire logic                     wr_en,
    input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
    input  wire logic [WIDTH-1:0]         wr_data,
    // read port
    input  wire logic                     rd_en,
    input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
    output logic      [WIDTH-1:0]         rd_data
);

    // storage, no reset: contents are only used once written
    logic [WIDTH-1:0] mem_q [DEPTH];

    // write side
    always_ff @(posedge ref_clk) begin
        if (wr_en) begin
            mem_q[wr_addr] <= wr_data;
        end
    end

    // read side, data one cycle after the request
    always_ff @(posedge ref_clk) begin
        if (rd_en) begin
            rd_data <= mem_q[rd_addr];
        end
    end

endmodule

// file: pmr_result_bank_properties.sv
// read port checker of the power monitor result bank
module pmr_result_bank_properties
    import pmr_pkg::*;
#(
    parameter int RAW_W     = 20,
    parameter int AVG_DEPTH = 8
) (
    // clock and reset
    input wire logic                 ref_clk,
    input wire logic                 rst,
    // conversion strobe
    input wire logic                 conv_valid,
    // read port
    input wire logic                 rd_req,
    input wire logic [7:0]           rd_addr,
    input wire logic                 rd_bulk,
    input wire logic                 rd_ack,
    input wire logic                 rd_nack,
    input wire logic [PMR_ACC_W-1:0] rd_data
);
    int unsigned conv_cnt_q; // conversions since reset, saturating
    logic        mapped;     // offset inside the bank

    // count conversions; stops at depth so it never wraps
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            conv_cnt_q <= 0;
        end else if (conv_valid && conv_cnt_q < AVG_DEPTH) begin
            conv_cnt_q <= conv_cnt_q + 1;
        end
    end
    assign mapped = rd_addr >= PMR_OFS_ENERGY_ACC
                 && rd_addr <= PMR_OFS_SENSE_MIN;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    // single read of either rolling mean
    sequence s_mean_single;
        rd_req && !rd_bulk
        && (rd_addr == PMR_OFS_BUS_MEAN || rd_addr == PMR_OFS_SENSE_MEAN);
    endsequence

    a_one_answer: assert property (rd_req |=> rd_ack != rd_nack)
        else $error("read answer missing or doubled");
    a_unmapped_nack: assert property (rd_req && !mapped |=> rd_nack)
        else $error("unmapped read not refused");
    a_bulk_acked: assert property (rd_req && rd_bulk && mapped |=> rd_ack)
        else $error("bulk read refused");
    // pending conversions excluded: the count may lead the history
    a_mean_early: assert property (
        (s_mean_single ##0 conv_cnt_q < AVG_DEPTH - 1) |=> rd_nack)
        else $error("unfilled mean read not refused");
    a_mean_full: assert property (
        (s_mean_single ##0 (conv_cnt_q == AVG_DEPTH && !$past(conv_valid)
        && !$past(conv_valid, 2))) |=> rd_ack)
        else $error("filled mean read refused");
    a_nack_zero: assert property (rd_nack |-> rd_data == '0)
        else $error("data not cleared on refusal");
    a_data_holds: assert property (!rd_req |=> $stable(rd_data))
        else $error("read data moved without request");
    a_power_width: assert property (
        rd_ack && $past(rd_addr) == PMR_OFS_POWER |-> rd_data[55:32] == '0)
        else $error("power upper bits not zero");
    a_volt_width: assert property (
        rd_ack && $past(rd_addr) inside {[8'h04:8'h07], [8'h09:8'h0B]}
        |-> rd_data[55:16] == '0)
        else $error("voltage upper bits not zero");
endmodule

bind pmr_result_bank pmr_result_bank_properties #(
    .RAW_W(RAW_W), .AVG_DEPTH(AVG_DEPTH)
) props_u (
    .ref_clk(ref_clk), .rst(rst), .conv_valid(conv_valid),
    .rd_req(rd_req), .rd_addr(rd_addr), .rd_bulk(rd_bulk),
    .rd_ack(rd_ack), .rd_nack(rd_nack), .rd_data(rd_data)
);

// file: pmr_host_model.sv
// host side model: issues reads on the result read port
module pmr_host_model
    import pmr_pkg::*;
(
    // clock
    input  wire logic                 ref_clk,
    // request
    output logic                      rd_req,
    output logic [7:0]                rd_addr,
    output logic                      rd_bulk,
    // answer
    input  wire logic                 rd_ack,
    input  wire logic                 rd_nack,
    input  wire logic [PMR_ACC_W-1:0] rd_data
);
    // idle bus at time zero
    initial begin
        rd_req  = 1'b0;
        rd_addr = 8'h00;
        rd_bulk = 1'b0;
    end

    // one read; address inverted after release so stale values show
    task automatic read(input logic [7:0] a, input logic bk,
                        output logic [PMR_ACC_W-1:0] d,
                        output logic ak, output logic ok);
        int n;
        @(negedge ref_clk);
        rd_req  = 1'b1;
        rd_addr = a;
        rd_bulk = bk;
        @(negedge ref_clk);
        rd_req  = 1'b0;
        rd_addr = ~a;
        rd_bulk = ~bk;
        // bounded wait for the registered answer
        for (n = 0; n < 3 && rd_ack !== 1'b1 && rd_nack !== 1'b1; n++) begin
            @(negedge ref_clk);
        end
        d  = rd_data;
        ak = rd_ack;
        ok = rd_ack === 1'b1 || rd_nack === 1'b1;
    endtask
endmodule

// file: tb.sv
// self-checking testbench of the power monitor result bank
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pmr_pkg::*;

    logic                 ref_clk = 1'b0;
    logic                 rst = 1'b1;
    logic                 conv_valid = 1'b0;
    logic [19:0]          conv_bus = '0;
    logic [19:0]          conv_sense = '0;
    logic                 bus_bipolar = 1'b0;
    logic                 sense_bipolar = 1'b0;
    logic [1:0]           accumulate_source_select = 2'h0;
    logic                 refresh = 1'b0;
    logic                 refresh_retain = 1'b0;
    logic                 rd_req, rd_bulk, rd_ack, rd_nack;
    logic [7:0]           rd_addr;
    logic [PMR_ACC_W-1:0] rd_data;
    logic [PMR_ACC_W-1:0] acc_m = '0;    // running sum model
    logic [PMR_ACC_W-1:0] acc_copy = '0; // readable sum model
    int                   mismatches = 0;
    int                   cmp_count = 0;

    // 40 MHz clock
    always #12.5 ref_clk = ~ref_clk;

    pmr_result_bank #(.RAW_W(20), .AVG_DEPTH(8)) dut_u (
        .ref_clk(ref_clk), .rst(rst), .conv_valid(conv_valid),
        .conv_bus(conv_bus), .conv_sense(conv_sense),
        .bus_bipolar(bus_bipolar), .sense_bipolar(sense_bipolar),
        .accumulate_source_select(accumulate_source_select),
        .refresh(refresh), .refresh_retain(refresh_retain),
        .rd_req(rd_req), .rd_addr(rd_addr), .rd_bulk(rd_bulk),
        .rd_ack(rd_ack), .rd_nack(rd_nack), .rd_data(rd_data)
    );
    pmr_host_model host_u (
        .ref_clk(ref_clk), .rd_req(rd_req), .rd_addr(rd_addr),
        .rd_bulk(rd_bulk), .rd_ack(rd_ack), .rd_nack(rd_nack),
        .rd_data(rd_data)
    );

    // verdict and end of run
    task automatic results();
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [55:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
            mismatches++;
        end
    endtask

    // read with expected answer; refused reads must return zero
    task automatic rd(input logic [7:0] a, input logic bk, input logic ea,
                      input logic [55:0] ed);
        logic [55:0] d;
        logic        ak, ok;
        host_u.read(a, bk, d, ak, ok);
        if (ok !== 1'b1) begin
            mismatches++;
            results();
        end
        check($sformatf("ack %h", a), {55'h0, ak}, {55'h0, ea});
        check($sformatf("reg %h", a), d, ed);
    endtask

    // expected power: signed operands, wide product, upper slice
    function automatic logic [31:0] pwr(logic [19:0] b, logic [19:0] s);
        logic signed [41:0] x;
        x = $signed({bus_bipolar & b[19], b})
          * $signed({sense_bipolar & s[19], s});
        return x[39:8];
    endfunction

    // one conversion; models the running sum first
    task automatic conv(input logic [19:0] b, input logic [19:0] s);
        case (accumulate_source_select)
            2'h1: acc_m += bus_bipolar ? 56'(signed'(b[19:4]))
                                       : 56'(b[19:4]);
            2'h2: acc_m += sense_bipolar ? 56'(signed'(s[19:4]))
                                         : 56'(s[19:4]);
            default: acc_m += (bus_bipolar || sense_bipolar)
                              ? 56'(signed'(pwr(b, s))) : 56'(pwr(b, s));
        endcase
        @(negedge ref_clk);
        conv_valid = 1'b1;
        conv_bus   = b;
        conv_sense = s;
        @(negedge ref_clk);
        conv_valid = 1'b0;
        conv_bus   = ~b;
        conv_sense = ~s;
        repeat (2) @(negedge ref_clk);
    endtask

    // clearing or retaining refresh pulse
    task automatic do_refresh(input logic clr);
        @(negedge ref_clk);
        refresh        = clr;
        refresh_retain = !clr;
        @(negedge ref_clk);
        refresh        = 1'b0;
        refresh_retain = 1'b0;
        acc_copy       = acc_m;
        if (clr) begin
            acc_m = '0;
        end
    endtask

    initial begin
        repeat (20) @(negedge ref_clk);
        rst = 1'b0;
        for (int a = 3; a < 12; a++) begin
            rd(8'(a), 1'b1, 1'b1, '0);
        end
        rd(8'h02, 1'b0, 1'b0, '0);
        rd(8'h0C, 1'b0, 1'b0, '0);
        for (int i = 1; i < 9; i++) begin
            conv(20'(i * 4096), 20'h00100);
            if (i == 4) rd(PMR_OFS_BUS_MEAN, 1'b1, 1'b1, 56'h140);
            if (i == 7) rd(PMR_OFS_SENSE_MEAN, 1'b0, 1'b0, '0);
        end
        rd(PMR_OFS_BUS_MEAN, 1'b0, 1'b1, 56'h0480);
        rd(PMR_OFS_SENSE_MEAN, 1'b0, 1'b1, 56'h0010);
        rd(PMR_OFS_BUS_SAMPLE, 1'b0, 1'b1, 56'h0800);
        rd(PMR_OFS_SENSE_SAMPLE, 1'b0, 1'b1, 56'h0010);
        rd(PMR_OFS_POWER, 1'b0, 1'b1, 56'h8000);
        rd(PMR_OFS_BUS_MIN, 1'b0, 1'b1, 56'h0100);
        rd(PMR_OFS_BUS_MAX, 1'b0, 1'b1, 56'h0800);
        rd(PMR_OFS_SENSE_MIN, 1'b0, 1'b1, 56'h0010);
        do_refresh(1'b0);
        rd(PMR_OFS_ENERGY_ACC, 1'b0, 1'b1, acc_copy);
        rd(PMR_OFS_BUS_MIN, 1'b0, 1'b1, 56'h0100);
        accumulate_source_select = 2'h1;
        conv(20'h00800, 20'h00100);
        do_refresh(1'b0);
        rd(PMR_OFS_ENERGY_ACC, 1'b0, 1'b1, acc_copy);
        rd(PMR_OFS_BUS_MIN, 1'b0, 1'b1, 56'h0080);
        accumulate_source_select = 2'h2;
        conv(20'h01000, 20'h00200);
        do_refresh(1'b1);
        rd(PMR_OFS_ENERGY_ACC, 1'b0, 1'b1, acc_copy);
        rd(PMR_OFS_BUS_MAX, 1'b0, 1'b1, '0);
        rd(PMR_OFS_SENSE_MIN, 1'b0, 1'b1, '0);
        rd(PMR_OFS_BUS_SAMPLE, 1'b0, 1'b1, 56'h0100);
        rd(PMR_OFS_POWER, 1'b0, 1'b1, 56'h2000);
        rd(PMR_OFS_BUS_MEAN, 1'b0, 1'b1, 56'h0450);
        conv(20'h05000, 20'h00100);
        rd(PMR_OFS_BUS_MIN, 1'b0, 1'b1, 56'h0500);
        do_refresh(1'b1);
        rd(PMR_OFS_ENERGY_ACC, 1'b0, 1'b1, 56'h10);
        do_refresh(1'b1);
        rd(PMR_OFS_ENERGY_ACC, 1'b0, 1'b1, '0);
        accumulate_source_select = 2'h0;
        sense_bipolar = 1'b1;
        conv(20'h12340, 20'hFFF00);
        rd(PMR_OFS_POWER, 1'b0, 1'b1, 56'hFFFE_DCC0);
        rd(PMR_OFS_SENSE_MIN, 1'b0, 1'b1, 56'hFFF0);
        do_refresh(1'b1);
        rd(PMR_OFS_ENERGY_ACC, 1'b0, 1'b1, 56'hFF_FFFF_FFFE_DCC0);
        bus_bipolar   = 1'b1;
        sense_bipolar = 1'b0;
        accumulate_source_select = 2'h1;
        conv(20'hF0000, 20'h00200);
        accumulate_source_select = 2'h3;
        conv(20'h01000, 20'h00200);
        rd(PMR_OFS_BUS_MIN, 1'b0, 1'b1, 56'hF000);
        rd(PMR_OFS_BUS_MAX, 1'b0, 1'b1, 56'h0100);
        rd(PMR_OFS_POWER, 1'b0, 1'b1, 56'h2000);
        do_refresh(1'b1);
        rd(PMR_OFS_ENERGY_ACC, 1'b0, 1'b1, 56'h1000);
        results();
    end
endmodule
